//--- rtl/cie_pkg.sv
// Register map, encodings and types shared by the instruction subset core
package cie_pkg;
	// ==========================================
	// Register map (byte addresses)
	localparam logic [11:0] CIE_ADDR_INSTR = 12'h000;
	localparam logic [11:0] CIE_ADDR_W = 12'h004;
	localparam logic [11:0] CIE_ADDR_STATUS = 12'h008;
	localparam logic [11:0] CIE_ADDR_PTR0 = 12'h00C;
	localparam logic [11:0] CIE_ADDR_PTR1 = 12'h010;
	localparam logic [11:0] CIE_ADDR_PC = 12'h014;
	localparam logic [11:0] CIE_ADDR_STACK = 12'h018;
	localparam logic [11:0] CIE_ADDR_DIR = 12'h01C;
	localparam logic [11:0] CIE_ADDR_WDOG = 12'h020;
	localparam logic [11:0] CIE_REG_STRIDE = 12'h004;
	localparam logic [2:0] CIE_MEM_REGION = 3'h1;
	localparam int CIE_MEM_REGION_LSB = 9;
	localparam int CIE_MEM_LSB = 2;
	localparam logic [2:0] CIE_HSIZE_WORD = 3'h2;
	// ==========================================
	// Status word bit positions
	localparam int CIE_ST_C = 0;
	localparam int CIE_ST_DC = 1;
	localparam int CIE_ST_Z = 2;
	localparam int CIE_ST_TO = 3;
	localparam int CIE_ST_PD = 4;
	localparam int CIE_ST_GIE = 5;
	localparam int CIE_ST_RI = 6;
	localparam int CIE_ST_SLEEP = 7;
	// ==========================================
	// File addresses, reset values, steps
	localparam logic [6:0] CIE_WIN0_FILE = 7'h00;
	localparam logic [6:0] CIE_WIN1_FILE = 7'h01;
	localparam logic [6:0] CIE_DIR_A_FILE = 7'h05;
	localparam logic [6:0] CIE_DIR_B_FILE = 7'h06;
	localparam logic [6:0] CIE_DIR_C_FILE = 7'h07;
	localparam logic [7:0] CIE_DIR_RESET = 8'hFF;
	localparam logic [15:0] CIE_PTR_STEP = 16'h0001;
	// ==========================================
	// Types
	typedef enum logic [4:0] {
		CIE_OP_NOP = 5'h00, CIE_OP_STORE_IND = 5'h01, CIE_OP_STORE_REL = 5'h02,
		CIE_OP_SWRESET = 5'h03, CIE_OP_RETURN_FROM_INTERRUPT = 5'h04, CIE_OP_RETURN_WITH_LITERAL = 5'h05,
		CIE_OP_RETURN = 5'h06, CIE_OP_RRF = 5'h07, CIE_OP_RLF = 5'h08,
		CIE_OP_SLEEP = 5'h09, CIE_OP_SUBTRACT_W_FROM_FILE = 5'h0A, CIE_OP_SUBTRACT_W_BORROW = 5'h0B,
		CIE_OP_SUBTRACT_W_FROM_LITERAL = 5'h0C, CIE_OP_SWAP = 5'h0D, CIE_OP_DIRLOAD = 5'h0E,
		CIE_OP_XOR_LITERAL_W = 5'h0F, CIE_OP_XOR_W_FILE = 5'h10
	} cie_op_t;
	typedef enum logic [1:0] {
		CIE_PRE_INC = 2'h0, CIE_PRE_DEC = 2'h1, CIE_POST_INC = 2'h2, CIE_POST_DEC = 2'h3
	} cie_mode_t;
	typedef enum logic [2:0] {
		CIE_EX_IDLE = 3'h1, CIE_EX_RUN = 3'h2, CIE_EX_FLUSH = 3'h4
	} cie_ex_state_t;
	typedef struct packed {
		cie_op_t op;
		logic ptrSel;
		cie_mode_t mode;
		logic dest;
		logic [6:0] file;
	} cie_instr_t;
	typedef struct packed {
		logic z;
		logic dc;
		logic c;
	} cie_flags_t;
	typedef struct packed {
		logic valid;
		logic write;
		logic wordSize;
		logic [11:0] addr;
	} cie_dphase_t;
endpackage : cie_pkg

//--- rtl/cie_exec_core.sv
// Instruction subset execution core with an AHB-Lite register slave
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module cie_exec_core
	import cie_pkg::*;
#(
	parameter int DATA_DEPTH = 128,
	parameter int STACK_DEPTH = 16,
	parameter int PC_W = 15,
	parameter int WDOG_PRE_W = 8
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic [7:0] dirPortA,
	output logic [7:0] dirPortB,
	output logic [7:0] dirPortC,
	output logic sleepActive
);
	localparam int MEM_AW = $clog2(DATA_DEPTH);
	localparam int SP_W = $clog2(STACK_DEPTH);

	// ==========================================
	// State
	cie_ex_state_t exState_q;
	cie_instr_t instr_q;
	cie_dphase_t dp_q;
	cie_flags_t flags_q;
	logic [7:0] wReg_q;
	logic gie_q, to_q, pd_q, ri_q, swRst_q;
	logic [15:0] ptr_q [2];
	logic [PC_W-1:0] pc_q;
	logic [PC_W-1:0] stack_q [STACK_DEPTH];
	logic [SP_W-1:0] sp_q;
	logic [7:0] mem_q [DATA_DEPTH];
	logic [7:0] wdog_q;
	logic [WDOG_PRE_W-1:0] wdogPre_q;
	logic hreadyout_q, hresp_q, sleep_q;
	logic [31:0] hrdata_q;
	logic [7:0] dirA_q, dirB_q, dirC_q;

	// ==========================================
	// Bus decode
	logic addrPhase, busWr, launch, coreRst, running, memHit;
	logic [MEM_AW-1:0] busMemIdx;
	logic [31:0] rdData;

	assign addrPhase = hsel && htrans[1] && hready;
	assign busWr = dp_q.valid && dp_q.write && dp_q.wordSize && hreadyout_q;
	assign launch = busWr && (dp_q.addr == CIE_ADDR_INSTR);
	assign memHit = dp_q.addr[11:CIE_MEM_REGION_LSB] == CIE_MEM_REGION;
	assign busMemIdx = dp_q.addr[CIE_MEM_LSB +: MEM_AW];
	// Software reset acts one cycle after the instruction, on the core only
	assign coreRst = !rst_b || swRst_q;
	assign running = exState_q == CIE_EX_RUN;

	// ==========================================
	// Operand fetch and window redirection
	logic [MEM_AW-1:0] fileIdx, indIdx;
	logic [7:0] srcF, kLit, result;
	logic [5:0] relK;
	logic [15:0] selPtr, newPtr, indAddr;
	logic [PC_W-1:0] stackTop;

	assign kLit = {instr_q.dest, instr_q.file};
	assign relK = instr_q.file[5:0];
	assign selPtr = ptr_q[instr_q.ptrSel];
	assign stackTop = stack_q[sp_q - 1'b1];
	assign indIdx = indAddr[MEM_AW-1:0];
	assign srcF = mem_q[fileIdx];

	always_comb begin
		// Window files hold nothing; the pointer supplies the address
		if (instr_q.file == CIE_WIN0_FILE) begin
			fileIdx = ptr_q[0][MEM_AW-1:0];
		end else if (instr_q.file == CIE_WIN1_FILE) begin
			fileIdx = ptr_q[1][MEM_AW-1:0];
		end else begin
			fileIdx = MEM_AW'(instr_q.file);
		end
	end

	// ==========================================
	// Subtractor: a + ~b + cin gives a - b - borrow
	logic [7:0] subA;
	logic subCin;
	logic [8:0] subSum;
	logic [4:0] subHalf;

	assign subA = (instr_q.op == CIE_OP_SUBTRACT_W_FROM_LITERAL) ? kLit : srcF;
	assign subCin = (instr_q.op == CIE_OP_SUBTRACT_W_BORROW) ? flags_q.c : 1'b1;
	assign subSum = {1'b0, subA} + {1'b0, ~wReg_q} + {8'h00, subCin};
	assign subHalf = {1'b0, subA[3:0]} + {1'b0, ~wReg_q[3:0]} + {4'h0, subCin};

	// ==========================================
	// Instruction decode
	logic fileOp, wrW, wrF, updC, updDC, updZ, newC, newDC;
	logic flowOp, pop, setGie, doSleep, doSwRst, dirWr, indWr, ptrWr;

	always_comb begin
		fileOp = 1'b0;
		wrW = 1'b0;
		result = srcF;
		updC = 1'b0;
		updDC = 1'b0;
		updZ = 1'b0;
		newC = flags_q.c;
		newDC = flags_q.dc;
		flowOp = 1'b0;
		pop = 1'b0;
		setGie = 1'b0;
		doSleep = 1'b0;
		doSwRst = 1'b0;
		dirWr = 1'b0;
		indWr = 1'b0;
		ptrWr = 1'b0;
		newPtr = selPtr;
		indAddr = selPtr;
		unique case (instr_q.op)
			CIE_OP_STORE_IND: begin
				indWr = 1'b1;
				ptrWr = 1'b1;
				// Plain 16-bit arithmetic wraps at both ends
				if (instr_q.mode inside {CIE_PRE_DEC, CIE_POST_DEC}) begin
					newPtr = selPtr - CIE_PTR_STEP;
				end else begin
					newPtr = selPtr + CIE_PTR_STEP;
				end
				indAddr = (instr_q.mode inside {CIE_POST_INC, CIE_POST_DEC}) ?
					selPtr : newPtr;
			end
			CIE_OP_STORE_REL: begin
				indWr = 1'b1;
				indAddr = selPtr + {{10{relK[5]}}, relK};
			end
			CIE_OP_SWRESET: begin
				doSwRst = 1'b1;
			end
			CIE_OP_RETURN_FROM_INTERRUPT: begin
				flowOp = 1'b1;
				pop = 1'b1;
				setGie = 1'b1;
			end
			CIE_OP_RETURN_WITH_LITERAL: begin
				flowOp = 1'b1;
				pop = 1'b1;
				wrW = 1'b1;
				result = kLit;
			end
			CIE_OP_RETURN: begin
				flowOp = 1'b1;
				pop = 1'b1;
			end
			CIE_OP_RRF: begin
				fileOp = 1'b1;
				result = {flags_q.c, srcF[7:1]};
				newC = srcF[0];
				updC = 1'b1;
			end
			CIE_OP_RLF: begin
				fileOp = 1'b1;
				result = {srcF[6:0], flags_q.c};
				newC = srcF[7];
				updC = 1'b1;
			end
			CIE_OP_SLEEP: begin
				doSleep = 1'b1;
			end
			CIE_OP_SUBTRACT_W_FROM_FILE, CIE_OP_SUBTRACT_W_BORROW: begin
				fileOp = 1'b1;
				result = subSum[7:0];
				newC = subSum[8];
				newDC = subHalf[4];
				updC = 1'b1;
				updDC = 1'b1;
				updZ = 1'b1;
			end
			CIE_OP_SUBTRACT_W_FROM_LITERAL: begin
				wrW = 1'b1;
				result = subSum[7:0];
				newC = subSum[8];
				newDC = subHalf[4];
				updC = 1'b1;
				updDC = 1'b1;
				updZ = 1'b1;
			end
			CIE_OP_SWAP: begin
				fileOp = 1'b1;
				result = {srcF[3:0], srcF[7:4]};
			end
			CIE_OP_DIRLOAD: begin
				dirWr = 1'b1;
			end
			CIE_OP_XOR_LITERAL_W: begin
				wrW = 1'b1;
				result = wReg_q ^ kLit;
				updZ = 1'b1;
			end
			CIE_OP_XOR_W_FILE: begin
				fileOp = 1'b1;
				result = wReg_q ^ srcF;
				updZ = 1'b1;
			end
			default: begin
			end
		endcase
		if (fileOp && !instr_q.dest) begin
			wrW = 1'b1;
		end
		wrF = fileOp && instr_q.dest;
	end

	// ==========================================
	// Execution sequence
	always_ff @(posedge ref_clk) begin
		if (coreRst) begin
			exState_q <= CIE_EX_IDLE;
		end else begin
			unique case (exState_q)
				CIE_EX_IDLE: begin
					if (launch) begin
						exState_q <= CIE_EX_RUN;
					end
				end
				CIE_EX_RUN: begin
					// Flow changes spend a second cycle flushing the fetch
					exState_q <= flowOp ? CIE_EX_FLUSH : CIE_EX_IDLE;
				end
				CIE_EX_FLUSH: begin
					exState_q <= CIE_EX_IDLE;
				end
				default: begin
					exState_q <= CIE_EX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (coreRst) begin
			instr_q <= '0;
		end else if (launch) begin
			instr_q <= hwdata[15:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			swRst_q <= 1'b0;
		end else begin
			swRst_q <= running && doSwRst;
		end
	end

	// ==========================================
	// Working register and flags
	always_ff @(posedge ref_clk) begin
		if (coreRst) begin
			wReg_q <= '0;
		end else if (running && wrW) begin
			wReg_q <= result;
		end else if (busWr && dp_q.addr == CIE_ADDR_W) begin
			wReg_q <= hwdata[7:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (coreRst) begin
			flags_q <= '0;
			gie_q <= 1'b0;
		end else if (running) begin
			// Flags move only where the decode asks; stores touch none
			if (updC) begin
				flags_q.c <= newC;
			end
			if (updDC) begin
				flags_q.dc <= newDC;
			end
			if (updZ) begin
				flags_q.z <= result == 8'h00;
			end
			if (setGie) begin
				gie_q <= 1'b1;
			end
		end else if (busWr && dp_q.addr == CIE_ADDR_STATUS) begin
			flags_q.c <= hwdata[CIE_ST_C];
			flags_q.dc <= hwdata[CIE_ST_DC];
			flags_q.z <= hwdata[CIE_ST_Z];
			gie_q <= hwdata[CIE_ST_GIE];
		end
	end

	// ==========================================
	// Power status and watchdog
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			to_q <= 1'b1;
			pd_q <= 1'b1;
			ri_q <= 1'b1;
		end else if (running && doSleep) begin
			to_q <= 1'b1;
			pd_q <= 1'b0;
		end else if (running && doSwRst) begin
			// Survives the core reset so software can read the cause
			ri_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (coreRst || launch) begin
			sleep_q <= 1'b0;
		end else if (running && doSleep) begin
			sleep_q <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (coreRst || (running && doSleep)) begin
			wdog_q <= '0;
			wdogPre_q <= '0;
		end else begin
			wdogPre_q <= wdogPre_q + 1'b1;
			if (&wdogPre_q) begin
				wdog_q <= wdog_q + 8'h01;
			end
		end
	end

	// ==========================================
	// Pointers, one per window
	for (genvar n = 0; n < 2; n++) begin : g_ptr
		always_ff @(posedge ref_clk) begin
			if (coreRst) begin
				ptr_q[n] <= '0;
			end else if (running && ptrWr && instr_q.ptrSel == 1'(n)) begin
				ptr_q[n] <= newPtr;
			end else if (busWr && dp_q.addr == CIE_ADDR_PTR0 + 12'(n) * CIE_REG_STRIDE) begin
				ptr_q[n] <= hwdata[15:0];
			end
		end
	end

	// ==========================================
	// Program counter and return stack
	always_ff @(posedge ref_clk) begin
		if (coreRst) begin
			pc_q <= '0;
			sp_q <= '0;
		end else if (running) begin
			if (pop) begin
				pc_q <= stackTop;
				sp_q <= sp_q - 1'b1;
			end else begin
				pc_q <= pc_q + 1'b1;
			end
		end else if (busWr && dp_q.addr == CIE_ADDR_PC) begin
			pc_q <= hwdata[PC_W-1:0];
		end else if (busWr && dp_q.addr == CIE_ADDR_STACK) begin
			stack_q[sp_q] <= hwdata[PC_W-1:0];
			sp_q <= sp_q + 1'b1;
		end
	end

	// ==========================================
	// Data file
	always_ff @(posedge ref_clk) begin
		if (running && wrF) begin
			mem_q[fileIdx] <= result;
		end else if (running && indWr) begin
			mem_q[indIdx] <= wReg_q;
		end else if (busWr && memHit) begin
			mem_q[busMemIdx] <= hwdata[7:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (coreRst) begin
			dirA_q <= CIE_DIR_RESET;
			dirB_q <= CIE_DIR_RESET;
			dirC_q <= CIE_DIR_RESET;
		end else if (running && dirWr) begin
			// Other operand values leave all three alone
			if (instr_q.file == CIE_DIR_A_FILE) begin
				dirA_q <= wReg_q;
			end
			if (instr_q.file == CIE_DIR_B_FILE) begin
				dirB_q <= wReg_q;
			end
			if (instr_q.file == CIE_DIR_C_FILE) begin
				dirC_q <= wReg_q;
			end
		end
	end

	// ==========================================
	// AHB-Lite slave
	always_comb begin
		rdData = '0;
		case (dp_q.addr)
			CIE_ADDR_INSTR: rdData = 32'(instr_q);
			CIE_ADDR_W: rdData = 32'(wReg_q);
			CIE_ADDR_STATUS: begin
				rdData[CIE_ST_C] = flags_q.c;
				rdData[CIE_ST_DC] = flags_q.dc;
				rdData[CIE_ST_Z] = flags_q.z;
				rdData[CIE_ST_TO] = to_q;
				rdData[CIE_ST_PD] = pd_q;
				rdData[CIE_ST_GIE] = gie_q;
				rdData[CIE_ST_RI] = ri_q;
				rdData[CIE_ST_SLEEP] = sleep_q;
			end
			CIE_ADDR_PTR0: rdData = 32'(ptr_q[0]);
			CIE_ADDR_PTR1: rdData = 32'(ptr_q[1]);
			CIE_ADDR_PC: rdData = 32'(pc_q);
			CIE_ADDR_STACK: rdData = 32'(stackTop);
			CIE_ADDR_DIR: rdData = {8'h00, dirC_q, dirB_q, dirA_q};
			CIE_ADDR_WDOG: rdData = 32'(wdog_q);
			default: rdData = memHit ? 32'(mem_q[busMemIdx]) : 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			dp_q <= '0;
		end else if (addrPhase) begin
			dp_q <= {1'b1, hwrite, hsize == CIE_HSIZE_WORD, haddr[11:0]};
		end else if (hreadyout_q) begin
			dp_q.valid <= 1'b0;
		end
	end

	// Reads always take one wait; a launch stalls the bus until the core idles
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			hreadyout_q <= 1'b1;
			hrdata_q <= '0;
			hresp_q <= 1'b0;
		end else if (launch || (addrPhase && !hwrite)) begin
			hreadyout_q <= 1'b0;
		end else if (!hreadyout_q && exState_q == CIE_EX_IDLE && !swRst_q) begin
			hreadyout_q <= 1'b1;
			hrdata_q <= rdData;
		end
	end

	assign hreadyout = hreadyout_q;
	assign hrdata = hrdata_q;
	assign hresp = hresp_q;
	assign dirPortA = dirA_q;
	assign dirPortB = dirB_q;
	assign dirPortC = dirC_q;
	assign sleepActive = sleep_q;

	// ==========================================
	// Checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	sequence sRunOp(cie_op_t op);
		running && instr_q.op == op;
	endsequence
	sequence sFlushThenIdle;
		exState_q == CIE_EX_FLUSH ##1 exState_q == CIE_EX_IDLE;
	endsequence

	a_post_inc_ptr: assert property (
		sRunOp(CIE_OP_STORE_IND) and ##0 (instr_q.mode == CIE_POST_INC)
		|=> ptr_q[instr_q.ptrSel] == $past(selPtr) + CIE_PTR_STEP && !swRst_q)
		else $error("post increment pointer wrong");
	a_rel_ptr_kept: assert property (sRunOp(CIE_OP_STORE_REL) |=>
		$stable(ptr_q[0]) && $stable(ptr_q[1]))
		else $error("relative store moved a pointer");
	a_ptr_wrap_top: assert property (
		sRunOp(CIE_OP_STORE_IND) and ##0 (instr_q.mode inside {CIE_PRE_INC, CIE_POST_INC} &&
		selPtr == 16'hFFFF) |=> ptr_q[instr_q.ptrSel] == 16'h0000)
		else $error("pointer did not wrap");
	a_store_flags: assert property (sRunOp(CIE_OP_STORE_IND) |=> $stable(flags_q))
		else $error("indirect store changed flags");
	a_swreset_ri: assert property (sRunOp(CIE_OP_SWRESET) |=>
		!ri_q && swRst_q ##1 wReg_q == 8'h00 && exState_q == CIE_EX_IDLE)
		else $error("software reset sequence wrong");
	a_return_from_interrupt_gie: assert property (sRunOp(CIE_OP_RETURN_FROM_INTERRUPT) |=>
		gie_q && pc_q == $past(stackTop) and sFlushThenIdle)
		else $error("interrupt return wrong");
	a_return_with_literal_load: assert property (sRunOp(CIE_OP_RETURN_WITH_LITERAL) |=>
		wReg_q == $past(kLit) && pc_q == $past(stackTop))
		else $error("literal return wrong");
	a_return_two: assert property (sRunOp(CIE_OP_RETURN) |=> sFlushThenIdle)
		else $error("subroutine return not two cycles");
	a_rrf_carry: assert property (sRunOp(CIE_OP_RRF) |=>
		flags_q.c == $past(srcF[0]) && flags_q.z == $past(flags_q.z))
		else $error("rotate right carry wrong");
	a_sleep_flags: assert property (sRunOp(CIE_OP_SLEEP) |=>
		to_q && !pd_q && wdog_q == 8'h00 && sleep_q)
		else $error("sleep entry status wrong");
	a_subtract_w_from_file_carry: assert property (sRunOp(CIE_OP_SUBTRACT_W_FROM_FILE) |=>
		flags_q.c == ($past(wReg_q) <= $past(srcF)))
		else $error("subtract carry wrong");
	a_dir_load_b: assert property (
		sRunOp(CIE_OP_DIRLOAD) and ##0 instr_q.file == CIE_DIR_B_FILE
		|=> dirPortB == $past(wReg_q) && $stable(dirPortA))
		else $error("direction load wrong");
	a_one_cycle: assert property (running && !flowOp |=> exState_q == CIE_EX_IDLE)
		else $error("single cycle instruction overran");
endmodule : cie_exec_core

//--- testbench/cie_ahb_master.sv
// Bus master partner issuing single word transfers to the core
`timescale 1ns/1ps
module cie_ahb_master
	import cie_pkg::*;
(
	input wire logic ref_clk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = CIE_HSIZE_WORD;
		hwdata = 32'h0000_0000;
	end
	// ==========================================
	// One transfer; the bench timeout ends any endless wait
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= {20'h0_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge ref_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hready !== 1'b1);
		r = hrdata;
	endtask : xfer
endmodule : cie_ahb_master

//--- testbench/tb.sv
// Self-checking bench for the instruction subset core
`timescale 1ns/1ps
module tb
	import cie_pkg::*;
;
	logic refClk, rstB, hsel, hwrite, hready, hresp, sleepActive;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic [7:0] dirPortA, dirPortB, dirPortC;
	int errCount, checked, cycles, n;
	logic [31:0] r;

	cie_exec_core dut (.ref_clk(refClk), .rst_b(rstB), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .dirPortA(dirPortA),
		.dirPortB(dirPortB), .dirPortC(dirPortC), .sleepActive(sleepActive));
	cie_ahb_master m (.ref_clk(refClk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	initial begin
		refClk = 1'b0;
		forever #12.5 refClk = ~refClk;
	end
	// ==========================================
	// Helpers
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errCount++;
			$display("[FAIL] %s expected %h seen %h", s, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		m.xfer(a, 1'b1, d, x);
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] x);
		m.xfer(a, 1'b0, 32'h0000_0000, x);
	endtask : rd
	function automatic logic [11:0] fa(input logic [6:0] f);
		return {CIE_MEM_REGION, f, 2'b00};
	endfunction : fa
	function automatic logic [31:0] iw(cie_op_t o, logic s, cie_mode_t md, logic [7:0] k);
		return {16'h0000, o, s, md, k};
	endfunction : iw
	// Counts the stall cycles after the launch, bounded so a stuck slave ends the wait
	task automatic ex(input logic [31:0] w, output int c);
		wr(CIE_ADDR_INSTR, w);
		c = 0;
		do begin
			@(posedge refClk);
			#1;
			c++;
		end while (hready !== 1'b1 && c < 20);
	endtask : ex
	// ==========================================
	// Scenarios
	task automatic t_store;
		cie_mode_t md[4] = '{CIE_PRE_INC, CIE_PRE_DEC, CIE_POST_INC, CIE_POST_DEC};
		logic [15:0] p0[4] = '{16'h0010, 16'h0000, 16'hFFFF, 16'h0020};
		logic [15:0] p1[4] = '{16'h0011, 16'hFFFF, 16'h0000, 16'h001F};
		logic [6:0] fw[4] = '{7'h11, 7'h7F, 7'h7F, 7'h20};
		logic [11:0] pa;
		wr(CIE_ADDR_W, 32'h0000_00A5);
		wr(CIE_ADDR_STATUS, 32'h0000_0007);
		for (int i = 0; i < 4; i++) begin
			pa = i[1] ? CIE_ADDR_PTR1 : CIE_ADDR_PTR0;
			wr(fa(fw[i]), 32'h0000_0000);
			wr(pa, {16'h0000, p0[i]});
			ex(iw(CIE_OP_STORE_IND, i[1], md[i], 8'h00), n);
			rd(fa(fw[i]), r);
			chk("stored", r, 32'h0000_00A5);
			rd(pa, r);
			chk("pointer", r, {16'h0000, p1[i]});
			rd(CIE_ADDR_STATUS, r);
			chk("flags", r & 32'h0000_0007, 32'h0000_0007);
			chk("cycles", n, 2);
		end
	endtask : t_store
	task automatic t_rel;
		logic [5:0] off[2] = '{6'h20, 6'h1F};
		logic [6:0] fw[2] = '{7'h20, 7'h5F};
		wr(CIE_ADDR_PTR1, 32'h0000_0040);
		for (int i = 0; i < 2; i++) begin
			wr(CIE_ADDR_W, 32'h0000_003C + i);
			ex(iw(CIE_OP_STORE_REL, 1'b1, CIE_PRE_INC, {2'b00, off[i]}), n);
			rd(fa(fw[i]), r);
			chk("rel store", r, 32'h0000_003C + i);
			rd(CIE_ADDR_PTR1, r);
			chk("rel pointer", r, 32'h0000_0040);
		end
	endtask : t_rel
	task automatic t_window;
		wr(CIE_ADDR_PTR0, 32'h0000_0030);
		wr(fa(7'h30), 32'h0000_000F);
		wr(CIE_ADDR_W, 32'h0000_00F0);
		wr(CIE_ADDR_STATUS, 32'h0000_0001);
		ex(iw(CIE_OP_XOR_W_FILE, 1'b0, CIE_PRE_INC, 8'h80), n);
		rd(fa(7'h30), r);
		chk("xor file", r, 32'h0000_00FF);
		rd(CIE_ADDR_STATUS, r);
		chk("xor flags", r & 32'h0000_0007, 32'h0000_0001);
		wr(CIE_ADDR_W, 32'h0000_00FF);
		ex(iw(CIE_OP_XOR_W_FILE, 1'b0, CIE_PRE_INC, 8'h00), n);
		rd(CIE_ADDR_W, r);
		chk("xor w", r, 32'h0000_0000);
		rd(CIE_ADDR_STATUS, r);
		chk("xor zero", r & 32'h0000_0007, 32'h0000_0005);
	endtask : t_window
	task automatic t_rotate;
		wr(fa(7'h10), 32'h0000_00E6);
		wr(CIE_ADDR_STATUS, 32'h0000_0004);
		ex(iw(CIE_OP_RLF, 1'b0, CIE_PRE_INC, 8'h10), n);
		rd(CIE_ADDR_W, r);
		chk("rotl w", r, 32'h0000_00CC);
		rd(fa(7'h10), r);
		chk("rotl file", r, 32'h0000_00E6);
		rd(CIE_ADDR_STATUS, r);
		chk("rotl flags", r & 32'h0000_0007, 32'h0000_0005);
		ex(iw(CIE_OP_RRF, 1'b0, CIE_PRE_INC, 8'h90), n);
		rd(fa(7'h10), r);
		chk("rotr file", r, 32'h0000_00F3);
		rd(CIE_ADDR_STATUS, r);
		chk("rotr flags", r & 32'h0000_0007, 32'h0000_0004);
	endtask : t_rotate
	task automatic t_sub;
		cie_op_t op[7] = '{CIE_OP_SUBTRACT_W_FROM_FILE, CIE_OP_SUBTRACT_W_FROM_FILE, CIE_OP_SUBTRACT_W_FROM_FILE, CIE_OP_SUBTRACT_W_BORROW,
			CIE_OP_SUBTRACT_W_BORROW, CIE_OP_SUBTRACT_W_FROM_LITERAL, CIE_OP_SUBTRACT_W_FROM_LITERAL};
		logic [7:0] a[7] = '{8'h10, 8'h05, 8'h01, 8'h10, 8'h20, 8'h30, 8'h3F};
		logic [7:0] w[7] = '{8'h01, 8'h05, 8'h02, 8'h0F, 8'h01, 8'h31, 8'h0F};
		logic [6:0] cin = 7'b011_0100;
		logic [8:0] t9;
		logic [4:0] t5;
		logic b;
		for (int i = 0; i < 7; i++) begin
			b = (op[i] == CIE_OP_SUBTRACT_W_BORROW) & ~cin[i];
			t9 = {1'b0, a[i]} - {1'b0, w[i]} - {8'h00, b};
			t5 = {1'b0, a[i][3:0]} - {1'b0, w[i][3:0]} - {4'h0, b};
			wr(fa(7'h12), {24'h00_0000, a[i]});
			wr(CIE_ADDR_W, {24'h00_0000, w[i]});
			wr(CIE_ADDR_STATUS, {31'h0000_0000, cin[i]});
			ex(iw(op[i], 1'b0, CIE_PRE_INC, (op[i] == CIE_OP_SUBTRACT_W_FROM_LITERAL) ? a[i] : 8'h12), n);
			rd(CIE_ADDR_W, r);
			chk("difference", r, {24'h00_0000, t9[7:0]});
			rd(CIE_ADDR_STATUS, r);
			chk("sub flags", r & 32'h0000_0007,
				{29'h0000_0000, t9[7:0] == 8'h00, ~t5[4], ~t9[8]});
		end
	endtask : t_sub
	task automatic t_swap_dir;
		wr(CIE_ADDR_STATUS, 32'h0000_0003);
		wr(fa(7'h12), 32'h0000_003C);
		ex(iw(CIE_OP_SWAP, 1'b0, CIE_PRE_INC, 8'h92), n);
		rd(fa(7'h12), r);
		chk("swap", r, 32'h0000_00C3);
		for (int f = 5; f < 8; f++) begin
			wr(CIE_ADDR_W, 32'h0000_0010 + f);
			ex(iw(CIE_OP_DIRLOAD, 1'b0, CIE_PRE_INC, 8'h00 + f), n);
			chk("direction", {8'h00, dirPortC, dirPortB, dirPortA} >> (8 * (f - 5)) & 32'hFF,
				32'h0000_0010 + f);
		end
		rd(CIE_ADDR_STATUS, r);
		chk("no flags", r & 32'h0000_0007, 32'h0000_0003);
	endtask : t_swap_dir
	task automatic t_xor_literal_w;
		wr(CIE_ADDR_W, 32'h0000_005A);
		wr(CIE_ADDR_STATUS, 32'h0000_0003);
		ex(iw(CIE_OP_XOR_LITERAL_W, 1'b0, CIE_PRE_INC, 8'h5A), n);
		rd(CIE_ADDR_STATUS, r);
		chk("xor_literal_w zero", r & 32'h0000_0007, 32'h0000_0007);
		ex(iw(CIE_OP_XOR_LITERAL_W, 1'b0, CIE_PRE_INC, 8'h81), n);
		rd(CIE_ADDR_W, r);
		chk("xor_literal_w w", r, 32'h0000_0081);
		rd(CIE_ADDR_STATUS, r);
		chk("xor_literal_w flags", r & 32'h0000_0007, 32'h0000_0003);
	endtask : t_xor_literal_w
	task automatic t_returns;
		cie_op_t op[3] = '{CIE_OP_RETURN, CIE_OP_RETURN_WITH_LITERAL, CIE_OP_RETURN_FROM_INTERRUPT};
		for (int i = 0; i < 3; i++) begin
			wr(CIE_ADDR_STATUS, 32'h0000_0000);
			wr(CIE_ADDR_STACK, 32'h0000_2345 + i);
			ex(iw(op[i], 1'b0, CIE_PRE_INC, 8'h77), n);
			chk("flow cycles", n, 3);
			rd(CIE_ADDR_PC, r);
			chk("popped pc", r, 32'h0000_2345 + i);
			rd(CIE_ADDR_STATUS, r);
			chk("irq enable", r & 32'h0000_0020, (i == 2) ? 32'h0000_0020 : 32'h0);
		end
		rd(CIE_ADDR_W, r);
		chk("literal w", r, 32'h0000_0077);
	endtask : t_returns
	task automatic t_sleep_reset;
		repeat (600) @(posedge refClk);
		ex(iw(CIE_OP_SLEEP, 1'b0, CIE_PRE_INC, 8'h00), n);
		chk("asleep", sleepActive, 32'h1);
		rd(CIE_ADDR_WDOG, r);
		chk("watchdog", r, 32'h0000_0000);
		rd(CIE_ADDR_STATUS, r);
		chk("timeout pd", r & 32'h0000_0018, 32'h0000_0008);
		wr(CIE_ADDR_W, 32'h0000_0033);
		wr(CIE_ADDR_PTR0, 32'h0000_1234);
		ex(iw(CIE_OP_SWRESET, 1'b0, CIE_PRE_INC, 8'h00), n);
		rd(CIE_ADDR_W, r);
		chk("reset w", r, 32'h0000_0000);
		rd(CIE_ADDR_PTR0, r);
		chk("reset ptr", r, 32'h0000_0000);
		rd(CIE_ADDR_STATUS, r);
		chk("reset flag", r & 32'h0000_0040, 32'h0000_0000);
		chk("reset dir", dirPortA, 32'h0000_00FF);
	endtask : t_sleep_reset
	// ==========================================
	// Verdict and run control
	task automatic results;
		$display("Checks %0d, mismatches %0d", checked, errCount);
		if (errCount == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results
	always @(posedge refClk) begin
		cycles++;
		if (cycles == 20000) begin
			errCount++;
			results();
		end
	end
	initial begin
		errCount = 0;
		checked = 0;
		cycles = 0;
		rstB = 1'b0;
		repeat (5) @(posedge refClk);
		rstB <= 1'b1;
		chk("dir reset", dirPortA, 32'h0000_00FF);
		rd(CIE_ADDR_STATUS, r);
		chk("status reset", r, 32'h0000_0058);
		chk("okay", hresp, 32'h0);
		t_store();
		t_rel();
		t_window();
		t_rotate();
		t_sub();
		t_swap_dir();
		t_xor_literal_w();
		t_returns();
		t_sleep_reset();
		results();
	end
endmodule : tb
